// [ssc_slave_crc_protocol.sv]
// serial slave: framing, auto increment, crc and slave-active byte
// Function
// - every byte travels most significant bit first
// - drive on rising edge, sample on falling
// - act only on complete received bytes
// - chip select high aborts, crc resets
// - address auto increments, wraps to zero
// - crc byte appended only when count nonzero
// - low nibble: own slave bit low
// - high nibble: own bit low if crc matches
// - update command keeps transfer and crc running
// - zero command copies immediate values to snapshot
// - after last byte send ones, ignore master
// - snapshot mode routes accesses to update registers
// - crc restarts per transfer, covers command and data bytes
// - crc x8+x4+x3+x2+1, parallel byte step
// - crc remainder preset to all ones
// - crc remainder inverted before sending
// - slave number picks bit in each nibble
// - lock-protected two-bit slave number field held
// - mode clear reads immediate, set reads snapshot
// - update status bit toggles once in each cycle that has an update
`timescale 1ns/1ns
`default_nettype none
module ssc_slave_crc_protocol
  import ssc_slave_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int CNT_W  = 3
)(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              data_in,
  output logic                   data_out,
  output logic                   data_oe_n,
  input  wire logic              snapshot_mode_select,
  input  wire logic              lock_open,
  input  wire logic              auto_update,
  input  wire logic [7:0]        reg_rdata,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [7:0]             reg_wdata,
  output logic                   reg_we,
  output logic                   reg_re,
  output logic                   reg_snapshot,
  output logic                   update_pulse,
  output logic                   update_toggle,
  output logic [1:0]             slave_num
);
  import ssc_slave_pkg::*;

  logic [2:0]        sck_q;
  logic [2:0]        cs_q;
  logic [2:0]        dat_q;
  logic              sck_r;
  logic              cs_hi_r;
  logic              dat_r;
  logic              sck_rise;
  logic              sck_fall;
  ssc_state_type     state_r;
  logic [2:0]        bit_cnt_r;
  logic [6:0]        rx_sh_r;
  logic [7:0]        tx_sh_r;
  logic [7:0]        crc_r;
  logic [ADDR_W-1:0] addr_r;
  logic [CNT_W-1:0]  cnt_r;
  logic              dir_rd_r;
  logic              oe_n_r;
  logic              upd_pulse_r;
  logic              upd_tog_r;
  logic [1:0]        slave_num_r;
  logic              we_r;
  logic              re_r;
  logic              snap_r;
  logic [ADDR_W-1:0] raddr_r;
  logic [7:0]        wdata_r;
  logic [7:0]        rx_byte;
  logic [7:0]        crc_nxt;
  logic              byte_done;
  logic              busy;
  logic [3:0]        own_low;
  logic              crc_match;
  logic [7:0]        sact_byte;
  logic              is_update;
  logic [CNT_W-1:0]  cmd_cnt;
  logic [ADDR_W-1:0] cmd_addr;

  // one crc step over a whole byte, msb first, unrolled by the loop
  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic       fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[7] ^ d[i];
      r = {r[6:0], 1'b0};
      if (fb)
        r = r ^ CRC_POLY;
    end
    return r;
  endfunction

  // three-stage synchronisers; stage 0 is seen only by stage 1
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sck_q <= 3'h0;
      cs_q  <= 3'h7;
      dat_q <= 3'h7;
    end
    else
    begin
      sck_q <= {sck_q[1:0], sck};
      cs_q  <= {cs_q[1:0], cs_n};
      dat_q <= {dat_q[1:0], data_in};
    end
  end

  // filtered levels change only when stages 1 and 2 agree
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sck_r   <= 1'b0;
      cs_hi_r <= 1'b1;
      dat_r   <= 1'b1;
    end
    else
    begin
      if (sck_q[1] == sck_q[2])
        sck_r <= sck_q[2];
      if (cs_q[1] == cs_q[2])
        cs_hi_r <= cs_q[2];
      if (dat_q[1] == dat_q[2])
        dat_r <= dat_q[2];
    end
  end

  // edges of the filtered serial clock
  assign sck_rise = (sck_q[1] == sck_q[2]) && sck_q[2] && !sck_r;
  assign sck_fall = (sck_q[1] == sck_q[2]) && !sck_q[2] && sck_r;

  // received byte, msb first, and byte completion
  assign busy      = (state_r != ST_IDLE) && (state_r != ST_DONE);
  assign rx_byte   = {rx_sh_r, dat_r};
  assign byte_done = busy && !cs_hi_r && sck_fall && (bit_cnt_r == LAST_BIT);
  assign crc_nxt   = crc8_step(crc_r, rx_byte);
  // command fields
  assign cmd_cnt   = rx_byte[CMD_CNT_HI:CMD_CNT_LO];
  assign cmd_addr  = rx_byte[CMD_ADDR_HI:CMD_ADDR_LO];
  assign is_update = (rx_byte == UPDATE_CMD);
  // bus crc compared against the inverted remainder
  assign crc_match = (rx_byte == ~crc_r);
  assign own_low   = ~(4'h1 << slave_num_r);
  assign sact_byte = {crc_match ? own_low : 4'hf, own_low};

  // protocol sequencer; chip select high aborts at once
  always_ff @(posedge mclk)
  begin
    if (rst || cs_hi_r)
    begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      rx_sh_r   <= 7'h00;
      tx_sh_r   <= IDLE_LINE;
      crc_r     <= CRC_PRESET;
      addr_r    <= '0;
      cnt_r     <= '0;
      dir_rd_r  <= 1'b0;
    end
    else if (state_r == ST_IDLE)
    begin
      state_r <= ST_CMD;
    end
    else if (re_r)
    begin
      tx_sh_r <= reg_rdata; // read data loaded one cycle after strobe
    end
    else if (busy && sck_fall)
    begin
      // sample on falling edge, shift out next bit
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r   <= rx_byte[6:0];
      tx_sh_r   <= {tx_sh_r[6:0], 1'b1};
      if (byte_done)
      begin
        tx_sh_r <= IDLE_LINE;
        case (state_r)
          ST_CMD:
          begin
            crc_r <= crc_nxt;
            if (is_update)
              state_r <= ST_CMD;
            else if (cmd_cnt == '0)
              state_r <= ST_DONE;
            else
            begin
              state_r  <= ST_DATA;
              addr_r   <= cmd_addr;
              cnt_r    <= cmd_cnt;
              dir_rd_r <= rx_byte[CMD_DIR_BIT];
            end
          end
          ST_DATA:
          begin
            crc_r  <= crc_nxt;
            addr_r <= addr_r + ADDR_W'(1); // wraps to ADDR_WRAP
            cnt_r  <= cnt_r - CNT_W'(1);
            if (cnt_r == CNT_W'(ONE_BYTE))
            begin
              state_r <= ST_CRC;
              tx_sh_r <= ~crc_nxt;
            end
          end
          ST_CRC:
          begin
            state_r <= ST_SACT;
            tx_sh_r <= sact_byte;
          end
          default:
          begin
            state_r <= ST_DONE;
          end
        endcase
      end
    end
  end

  // open-drain drive: low for a zero, released otherwise
  always_ff @(posedge mclk)
  begin
    if (rst || cs_hi_r)
      oe_n_r <= 1'b1;
    else if (state_r == ST_DONE)
      oe_n_r <= 1'b1;
    else if (sck_rise)
      oe_n_r <= tx_sh_r[7];
  end

  assign data_out  = 1'b0;
  assign data_oe_n = oe_n_r;

  // register access strobes, one cycle each
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      we_r    <= 1'b0;
      re_r    <= 1'b0;
      snap_r  <= 1'b0;
      raddr_r <= '0;
      wdata_r <= 8'h00;
    end
    else
    begin
      we_r   <= byte_done && (state_r == ST_DATA) && !dir_rd_r;
      re_r   <= 1'b0;
      snap_r <= snapshot_mode_select;
      if (byte_done && (state_r == ST_DATA))
      begin
        raddr_r <= addr_r;
        wdata_r <= rx_byte;
        if (dir_rd_r && (cnt_r != CNT_W'(ONE_BYTE)))
        begin
          re_r    <= 1'b1;
          raddr_r <= addr_r + ADDR_W'(1);
        end
      end
      else if (byte_done && (state_r == ST_CMD) && !is_update && (cmd_cnt != '0) && rx_byte[CMD_DIR_BIT])
      begin
        re_r    <= 1'b1;
        raddr_r <= cmd_addr;
      end
    end
  end

  assign reg_we       = we_r;
  assign reg_re       = re_r;
  assign reg_addr     = raddr_r;
  assign reg_wdata    = wdata_r;
  assign reg_snapshot = snap_r;

  // update command pulse and status toggle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      upd_pulse_r <= 1'b0;
      upd_tog_r   <= 1'b0;
    end
    else
    begin
      upd_pulse_r <= byte_done && (state_r == ST_CMD) && is_update;
      if (upd_pulse_r || auto_update)
        upd_tog_r <= !upd_tog_r;
    end
  end

  assign update_pulse  = upd_pulse_r;
  assign update_toggle = upd_tog_r;

  // slave number field, written only while the lock is open
  always_ff @(posedge mclk)
  begin
    if (rst)
      slave_num_r <= SLAVE_NUM_RST;
    else if (we_r && lock_open && (raddr_r == SLAVE_REG_ADDR))
      slave_num_r <= wdata_r[SLAVE_NUM_HI:SLAVE_NUM_LO];
  end

  assign slave_num = slave_num_r;

  // checks on the sequencer
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_abort_to_idle: assert property (cs_hi_r |=> state_r == ST_IDLE)
    else $error("chip select high did not abort");
  a_crc_preset: assert property (state_r == ST_IDLE |-> crc_r == CRC_PRESET)
    else $error("crc not preset in idle");
  a_addr_wraps: assert property (byte_done && state_r == ST_DATA && addr_r == '1
    |=> addr_r == ADDR_WRAP)
    else $error("address did not wrap");
  a_crc_inverted: assert property (byte_done && state_r == ST_DATA && cnt_r == CNT_W'(ONE_BYTE)
    |=> state_r == ST_CRC && tx_sh_r == ~crc_r)
    else $error("crc byte not inverted remainder");
  a_slave_nibble: assert property (byte_done && state_r == ST_CRC
    |=> tx_sh_r[3:0] == ~(4'h1 << slave_num_r) && state_r == ST_SACT)
    else $error("slave bit wrong in low nibble");
  a_crc_check: assert property (byte_done && state_r == ST_CRC && rx_byte != ~crc_r
    |=> tx_sh_r[7:4] == 4'hf)
    else $error("high nibble low despite crc mismatch");
  a_no_crc_zero: assert property (byte_done && state_r == ST_CMD && !is_update && cmd_cnt == '0
    |=> state_r == ST_DONE)
    else $error("zero count did not end transfer");
  a_done_ones: assert property (state_r == ST_DONE |=> oe_n_r)
    else $error("line driven after transfer end");
  a_update_stay: assert property (byte_done && state_r == ST_CMD && is_update
    |=> state_r == ST_CMD ##1 $changed(upd_tog_r))
    else $error("update command mishandled");
  a_write_strobe: assert property (byte_done && state_r == ST_DATA && !dir_rd_r
    |=> we_r && wdata_r == $past(rx_byte))
    else $error("write strobe missing after byte");

  c_update_cmd: cover property (byte_done && state_r == ST_CMD && is_update);
  c_crc_pass: cover property (byte_done && state_r == ST_CRC && crc_match);
  c_read_burst: cover property (re_r && state_r == ST_DATA);
  c_abort_mid: cover property (cs_hi_r && state_r == ST_DATA);
endmodule
`default_nettype wire

// [ssc_slave_pkg.sv]
// constants, field layout and state codes for the serial slave
`default_nettype none
package ssc_slave_pkg;
  // command byte layout: direction, start address, byte count
  localparam int        CMD_DIR_BIT    = 7;
  localparam int        CMD_ADDR_HI    = 6;
  localparam int        CMD_ADDR_LO    = 3;
  localparam int        CMD_CNT_HI     = 2;
  localparam int        CMD_CNT_LO     = 0;
  localparam logic [7:0] UPDATE_CMD    = 8'h00;
  // address wrap target and slave number location
  localparam logic [3:0] ADDR_WRAP     = 4'h0;
  localparam logic [3:0] SLAVE_REG_ADDR = 4'hf;
  localparam int        SLAVE_NUM_HI   = 1;
  localparam int        SLAVE_NUM_LO   = 0;
  localparam logic [1:0] SLAVE_NUM_RST = 2'h0;
  // crc generator x^8+x^4+x^3+x^2+1 and preset
  localparam logic [7:0] CRC_POLY      = 8'h1d;
  localparam logic [7:0] CRC_PRESET    = 8'hff;
  // released line, all ones
  localparam logic [7:0] IDLE_LINE     = 8'hff;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [2:0] ONE_BYTE      = 3'h1;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD  = 6'b000010,
    ST_DATA = 6'b000100,
    ST_CRC  = 6'b001000,
    ST_SACT = 6'b010000,
    ST_DONE = 6'b100000
  } ssc_state_type;
endpackage
`default_nettype wire

// [ssc_master_model.sv]
// bus master model: select, serial clock and open-drain data pull
`timescale 1ns/1ns
`default_nettype none
module ssc_master_model (
  input  wire logic mclk,
  input  wire logic line,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic drv_n
);
  // idle: deselected, clock parked low, data released
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    drv_n = 1'b1;
  end

  // select early enough for the slave's synchroniser to settle
  task automatic open_frame();
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask

  // deselect long enough to restart, line let go
  task automatic close_frame();
    @(posedge mclk);
    cs_n <= 1'b1;
    drv_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  // one byte each way; long high phase lets the slave's late answer settle
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge mclk);
      sck <= 1'b1;
      drv_n <= tx[i];
      repeat (7) @(posedge mclk);
      rx[i] = line;
      sck <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// [ssc_slave_crc_protocol_tb.sv]
// self-checking bench for the serial slave with crc and slave-active byte
`timescale 1ns/1ns
`default_nettype none
module ssc_slave_crc_protocol_tb;
  import ssc_slave_pkg::*;
  typedef logic [7:0] bytes_type[$];
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       snapshot_mode_select = 1'b0;
  logic       lock_open = 1'b0;
  logic       auto_update = 1'b0;
  logic       cs_n, sck, drv_n, data_out, data_oe_n;
  logic       reg_we, reg_re, reg_snapshot, update_pulse, update_toggle;
  logic [7:0] reg_rdata, reg_wdata, w_data;
  logic [3:0] reg_addr, w_addr, r_addr;
  logic [1:0] slave_num;
  wire        line;
  int         n_errors = 0;
  int         compares = 0;
  int         n_upd = 0;

  always #4 mclk = ~mclk;
  // wired-AND with pull-up; register file answers its own address
  assign line = drv_n & (data_oe_n | data_out);
  assign reg_rdata = {4'h5, reg_addr};

  ssc_slave_crc_protocol ssc_slave_crc_protocol_inst (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck),
    .data_in(line), .data_out(data_out), .data_oe_n(data_oe_n), .snapshot_mode_select(snapshot_mode_select),
    .lock_open(lock_open), .auto_update(auto_update), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_snapshot(reg_snapshot),
    .update_pulse(update_pulse), .update_toggle(update_toggle), .slave_num(slave_num));
  ssc_master_model ssc_master_model_inst (.mclk(mclk), .line(line), .cs_n(cs_n), .sck(sck), .drv_n(drv_n));

  // remember the last strobed register access
  always @(posedge mclk)
  begin
    if (reg_we)
    begin
      w_addr <= reg_addr;
      w_data <= reg_wdata;
    end
    if (reg_re)
      r_addr <= reg_addr;
    if (update_pulse)
      n_upd <= n_upd + 1;
  end

  // reference crc, bitwise so it shares nothing with the parallel circuit
  function automatic logic [7:0] crc_of(input bytes_type q);
    logic [7:0] c;
    c = 8'hff;
    foreach (q[i])
      for (int k = 7; k >= 0; k--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][k]) ? 8'h1d : 8'h00);
    return ~c;
  endfunction

  function automatic logic [7:0] sa_of(input logic [1:0] n, input logic ok);
    logic [3:0] m;
    m = ~(4'h1 << n);
    return {ok ? m : 4'hf, m};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input bytes_type tx, output bytes_type rx);
    logic [7:0] b;
    rx = {};
    ssc_master_model_inst.open_frame();
    foreach (tx[i])
    begin
      ssc_master_model_inst.xfer(tx[i], b);
      rx.push_back(b);
    end
    ssc_master_model_inst.close_frame();
  endtask

  // aborted command, then a full write
  task automatic t_write();
    bytes_type rx;
    frame('{8'h01}, rx);
    frame('{8'h01, 8'h05, 8'hff, 8'hff, 8'hff}, rx);
    chk(rx[2], 8'h9b);
    chk(rx[3], sa_of(2'h0, 1'b1));
    chk(rx[4], 8'hff);
    chk({w_addr, w_data[3:0]}, 8'h05);
    chk({7'h0, reg_snapshot}, 8'h00);
  endtask

  // update command inside a transfer, then an outside update
  task automatic t_update();
    bytes_type rx;
    logic t0;
    t0 = update_toggle;
    frame('{8'h00, 8'h01, 8'h05, 8'hff, 8'hff}, rx);
    chk(rx[3], crc_of('{8'h00, 8'h01, 8'h05}));
    chk(8'(n_upd), 8'h01);
    chk({7'h0, update_toggle}, {7'h0, ~t0});
    @(posedge mclk) auto_update <= 1'b1;
    @(posedge mclk) auto_update <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({7'h0, update_toggle}, {7'h0, t0});
  endtask

  // zero-count non-update command ends the transfer
  task automatic t_zero();
    bytes_type rx;
    frame('{8'h08, 8'hff, 8'hff}, rx);
    chk(rx[1], 8'hff);
    chk(rx[2], 8'hff);
    // no write strobe: the write of 05 to address 0 must still be the last one
    chk({w_addr, w_data[3:0]}, 8'h05);
  endtask

  // slave number: locked, unlocked, then a corrupted crc read-back
  task automatic t_slave();
    bytes_type rx;
    frame('{8'h79, 8'h03, 8'hff, 8'hff}, rx);
    chk({6'h0, slave_num}, 8'h00);
    @(posedge mclk) lock_open <= 1'b1;
    frame('{8'h79, 8'h03, 8'hff, 8'hff}, rx);
    chk({6'h0, slave_num}, 8'h03);
    frame('{8'h01, 8'h05, 8'hff, 8'hff}, rx);
    chk(rx[3], 8'h77);
    frame('{8'h01, 8'h05, 8'hf7, 8'hff}, rx);
    chk(rx[2], 8'h93);
    chk(rx[3], sa_of(2'h3, 1'b0));
  endtask

  // snapshot read from the top address wraps to zero
  task automatic t_read();
    bytes_type rx;
    @(posedge mclk) snapshot_mode_select <= 1'b1;
    frame('{8'hfa, 8'hff, 8'hff, 8'hff, 8'hff}, rx);
    chk(rx[1], 8'h5f);
    chk(rx[2], 8'h50);
    chk({4'h0, r_addr}, 8'h00);
    chk(rx[3], crc_of('{8'hfa, 8'h5f, 8'h50}));
    chk(rx[4], sa_of(2'h3, 1'b1));
    chk({7'h0, reg_snapshot}, 8'h01);
  endtask

  task results();
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence; synchroniser reset values match the idle pins
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    t_write();
    t_update();
    t_zero();
    t_slave();
    t_read();
    results();
  end

  // watchdog well beyond the few dozen bytes sent
  initial
  begin
    #200000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
